// ===== hw/phy_cnt_params.svh
// Purpose: offsets, reset values and bus codes of the packet and error counters
// Assumes: 32-bit AXI4-Lite data, one word per register
// Notes:   register index times four is the byte address
`ifndef PHY_CNT_PARAMS_SVH
`define PHY_CNT_PARAMS_SVH

// bus address width and register index width
`define AXI_ADDR_W        8
`define REG_IDX_W         6

// register indices (byte address = index * 4)
`define IDX_IDLE_RX_ERR   6'h09
`define IDX_TX_PKT_HIGH   6'h0A
`define IDX_TX_PKT_MID    6'h0B
`define IDX_TX_PKT_LOW    6'h0C
`define IDX_COUNT_CTRL    6'h10

// counter widths and reset values
`define IDLE_CNT_W        16
`define TX_CNT_W          48
`define IDLE_CNT_RESET    16'h0000
`define TX_CNT_RESET      48'h0000_0000_0000

// control register: bit 0 idle counting enable, bit 1 tx counting enable
`define CTRL_IDLE_EN_BIT  0
`define CTRL_TX_EN_BIT    1
`define CTRL_RESET        2'h3

// response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define RESP_DECERR       2'h3

`endif

// ===== hw/phy_cnt_pkg.sv
// Purpose: bus carrier and state types of the packet and error counters
// Assumes: constants come from phy_cnt_params.svh
// Notes:   the state struct is the whole register set of the block
`include "phy_cnt_params.svh"

package phy_cnt_pkg;

	// master to slave signals of the register bus
	typedef struct packed {
		logic                   awvalid;
		logic [`AXI_ADDR_W-1:0] awaddr;
		logic                   wvalid;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bready;
		logic                   arvalid;
		logic [`AXI_ADDR_W-1:0] araddr;
		logic                   rready;
	} axi_req_type;

	// slave to master signals of the register bus
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_type;

	// every flip-flop of the block
	typedef struct packed {
		logic [1:0]                rx_sync1;
		logic [1:0]                rx_sync2;
		logic                      err_prev;
		logic [`IDLE_CNT_W-1:0]    idle_cnt;
		logic [`TX_CNT_W-1:0]      tx_cnt;
		logic [31:0]               tx_snap;
		logic [1:0]                ctrl;
		logic                      aw_held;
		logic [`REG_IDX_W-1:0]     aw_idx;
		logic                      w_held;
		logic [1:0]                w_ctl;
		logic                      w_strb0;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      rvalid;
		logic [31:0]               rdata;
		logic [1:0]                rresp;
	} cnt_state_type;

endpackage : phy_cnt_pkg

// ===== hw/phy_packet_error_counters.sv
// Purpose: idle receive error counter and 48-bit transmitted packet counter
// Assumes: rx control pin levels come from outside this clock; tx event is local
// Notes:   registers are read over AXI4-Lite; writes only reach the control word
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "phy_cnt_params.svh"

module phy_packet_error_counters (
	// clock and reset
	input  logic                     clk_sys,
	input  logic                     reset,
	// receive control line, level sampled at each rgmii clock edge
	input  logic                     rx_control_rise,
	input  logic                     rx_control_fall,
	// one-cycle pulse per transmitted packet, same clock
	input  logic                     tx_packet_done,
	// register bus
	input  phy_cnt_pkg::axi_req_type axi_req,
	output phy_cnt_pkg::axi_rsp_type axi_rsp
);
	import phy_cnt_pkg::*;

	cnt_state_type           s_r;
	cnt_state_type           s_nxt;
	logic                    rx_valid;
	logic                    rx_error;
	logic                    idle_hit;
	logic                    tx_hit;
	logic                    rd_take;
	logic [`REG_IDX_W-1:0]   rd_idx;
	logic                    idle_clear;
	logic                    high_clear;
	logic                    low_read;
	logic                    mid_read;
	logic                    aw_take;
	logic                    w_take;
	logic                    wr_do;

	// word index of a byte address; low two bits ignored
	function automatic logic [`REG_IDX_W-1:0] reg_index(input logic [`AXI_ADDR_W-1:0] a);
		reg_index = a[`AXI_ADDR_W-1:2];
	endfunction : reg_index

	// rgmii control decode: rise edge carries valid, rise xor fall carries error
	assign rx_valid = s_r.rx_sync2[1];
	assign rx_error = s_r.rx_sync2[1] ^ s_r.rx_sync2[0];

	// counting events, gated by the control word
	assign idle_hit = s_r.ctrl[`CTRL_IDLE_EN_BIT] && rx_error && !s_r.err_prev
		&& !rx_valid;
	assign tx_hit   = s_r.ctrl[`CTRL_TX_EN_BIT] && tx_packet_done;

	// read channel decode; one read in flight, so arready waits for rvalid to drop
	assign rd_take    = axi_req.arvalid && !s_r.rvalid;
	assign rd_idx     = reg_index(axi_req.araddr);
	assign idle_clear = rd_take && (rd_idx == `IDX_IDLE_RX_ERR);
	assign high_clear = rd_take && (rd_idx == `IDX_TX_PKT_HIGH);
	assign mid_read   = rd_take && (rd_idx == `IDX_TX_PKT_MID);
	assign low_read   = rd_take && (rd_idx == `IDX_TX_PKT_LOW);

	// write channels are taken independently, acted on once both are held
	assign aw_take = axi_req.awvalid && !s_r.aw_held && !s_r.bvalid;
	assign w_take  = axi_req.wvalid && !s_r.w_held && !s_r.bvalid;
	assign wr_do   = s_r.aw_held && s_r.w_held && !s_r.bvalid;

	// next state
	always_comb begin
		s_nxt = s_r;

		// two flops on the pin levels before the decode sees them
		s_nxt.rx_sync1 = {rx_control_rise, rx_control_fall};
		s_nxt.rx_sync2 = s_r.rx_sync1;
		s_nxt.err_prev = rx_error;

		// an event in the clearing cycle survives as a count of one
		s_nxt.idle_cnt = (idle_clear ? `IDLE_CNT_RESET : s_r.idle_cnt)
			+ `IDLE_CNT_W'(idle_hit);
		s_nxt.tx_cnt   = (high_clear ? `TX_CNT_RESET : s_r.tx_cnt)
			+ `TX_CNT_W'(tx_hit);

		// low read freezes the upper two words for the following reads;
		// a high read with no low read before it returns a stale snapshot,
		// while the live counter keeps counting as software walks the words
		if (low_read) begin
			s_nxt.tx_snap = s_r.tx_cnt[47:16];
		end

		// read data, captured at the address handshake
		if (rd_take) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = `RESP_OKAY;
			unique case (rd_idx)
				`IDX_IDLE_RX_ERR: s_nxt.rdata = {16'h0000, s_r.idle_cnt};
				`IDX_TX_PKT_HIGH: s_nxt.rdata = {16'h0000, s_r.tx_snap[31:16]};
				`IDX_TX_PKT_MID:  s_nxt.rdata = {16'h0000, s_r.tx_snap[15:0]};
				`IDX_TX_PKT_LOW:  s_nxt.rdata = {16'h0000, s_r.tx_cnt[15:0]};
				`IDX_COUNT_CTRL:  s_nxt.rdata = {30'h0000_0000, s_r.ctrl};
				default: begin
					s_nxt.rdata = 32'h0000_0000;
					s_nxt.rresp = `RESP_DECERR;
				end
			endcase
		end else if (s_r.rvalid && axi_req.rready) begin
			s_nxt.rvalid = 1'b0;
		end

		// write address and data holding
		if (aw_take) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_idx  = reg_index(axi_req.awaddr);
		end
		if (w_take) begin
			s_nxt.w_held  = 1'b1;
			s_nxt.w_ctl   = axi_req.wdata[1:0];
			s_nxt.w_strb0 = axi_req.wstrb[0];
		end

		// counters are read-only; a write to them is refused with slverr
		if (wr_do) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			unique case (s_r.aw_idx)
				`IDX_COUNT_CTRL: begin
					s_nxt.bresp = `RESP_OKAY;
					if (s_r.w_strb0) begin
						s_nxt.ctrl = s_r.w_ctl;
					end
				end
				`IDX_IDLE_RX_ERR,
				`IDX_TX_PKT_HIGH,
				`IDX_TX_PKT_MID,
				`IDX_TX_PKT_LOW:  s_nxt.bresp = `RESP_SLVERR;
				default:          s_nxt.bresp = `RESP_DECERR;
			endcase
		end else if (s_r.bvalid && axi_req.bready) begin
			s_nxt.bvalid = 1'b0;
		end
	end

	// state register, synchronous reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r          <= '0;
			s_r.idle_cnt <= `IDLE_CNT_RESET;
			s_r.tx_cnt   <= `TX_CNT_RESET;
			s_r.ctrl     <= `CTRL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// bus outputs; readies are combinational from state only
	always_comb begin
		axi_rsp.awready = !s_r.aw_held && !s_r.bvalid;
		axi_rsp.wready  = !s_r.w_held && !s_r.bvalid;
		axi_rsp.bvalid  = s_r.bvalid;
		axi_rsp.bresp   = s_r.bresp;
		axi_rsp.arready = !s_r.rvalid;
		axi_rsp.rvalid  = s_r.rvalid;
		axi_rsp.rdata   = s_r.rdata;
		axi_rsp.rresp   = s_r.rresp;
	end

	// checks on the counting and read behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	AST_IDLE_STEP: assert property (
		idle_hit && !idle_clear |=> s_r.idle_cnt == $past(s_r.idle_cnt) + 16'h0001)
		else $error("idle error counter did not step");

	AST_IDLE_CLEAR: assert property (
		idle_clear |=> axi_rsp.rvalid && axi_rsp.rdata[15:0] == $past(s_r.idle_cnt)
			&& s_r.idle_cnt == {15'h0000, $past(idle_hit)})
		else $error("idle error counter read did not return and clear");

	AST_DECODE_IDLE_ERR: assert property (
		(!rx_control_rise && rx_control_fall) [*3] |-> rx_error && !rx_valid)
		else $error("control line decode wrong for idle error");

	AST_TX_STEP: assert property (
		tx_hit && !high_clear |=> s_r.tx_cnt == $past(s_r.tx_cnt) + 48'h0000_0000_0001)
		else $error("transmit packet counter did not step");

	AST_LOW_WORD: assert property (
		low_read |=> axi_rsp.rvalid && axi_rsp.rdata == {16'h0000, $past(s_r.tx_cnt[15:0])})
		else $error("low word read returned wrong data");

	AST_HIGH_CLEAR: assert property (
		high_clear && !tx_hit |=> s_r.tx_cnt == 48'h0000_0000_0000)
		else $error("high word read did not clear the counter");

	AST_NO_SIDE: assert property (
		(low_read || mid_read) && !tx_hit |=> s_r.tx_cnt == $past(s_r.tx_cnt))
		else $error("low or mid read disturbed the counter");

	AST_SNAP_TAKE: assert property (
		low_read |=> s_r.tx_snap == $past(s_r.tx_cnt[47:16]))
		else $error("low word read did not capture the upper words");

	AST_SNAP_HOLD: assert property (
		!low_read |=> $stable(s_r.tx_snap))
		else $error("snapshot changed without a low read");

	// idle counter stays put unless an idle error edge or a clearing read
	AST_IDLE_HOLD: assert property (
		!idle_hit && !idle_clear |=> $stable(s_r.idle_cnt))
		else $error("idle error counter moved without an event");

	AST_IDLE_IN_DATA: assert property (
		rx_valid && !idle_clear |=> $stable(s_r.idle_cnt))
		else $error("error inside a frame reached the idle counter");

	AST_IDLE_LEVEL: assert property (
		s_r.err_prev && !idle_clear |=> $stable(s_r.idle_cnt))
		else $error("held error level counted more than once");

	AST_IDLE_GATED: assert property (
		!s_r.ctrl[`CTRL_IDLE_EN_BIT] && !idle_clear |=> $stable(s_r.idle_cnt))
		else $error("idle error counter stepped while switched off");

	// decode of the control line after the two synchroniser flops
	AST_DECODE_DATA: assert property (
		(rx_control_rise && !rx_control_fall) [*3] |-> rx_valid && rx_error)
		else $error("control line decode wrong for error inside data");

	AST_DECODE_QUIET: assert property (
		(rx_control_rise == rx_control_fall) [*3] |-> !rx_error)
		else $error("control line decode shows an error where none is");

	AST_SYNC_DELAY: assert property (
		rx_control_rise |-> ##2 rx_valid)
		else $error("valid level did not reach the decode two cycles later");

	// transmit counter holds, gating and the clear race
	AST_TX_HOLD: assert property (
		!tx_hit && !high_clear |=> $stable(s_r.tx_cnt))
		else $error("transmit packet counter moved without a packet");

	AST_TX_GATED: assert property (
		!s_r.ctrl[`CTRL_TX_EN_BIT] && !high_clear |=> $stable(s_r.tx_cnt))
		else $error("transmit packet counter stepped while switched off");

	AST_CLEAR_RACE: assert property (
		high_clear && tx_hit |=> s_r.tx_cnt == 48'h0000_0000_0001)
		else $error("packet in the clearing cycle was lost");

	// upper words come from the snapshot, not from the live counter
	AST_MID_WORD: assert property (
		mid_read |=> axi_rsp.rvalid
			&& axi_rsp.rdata == {16'h0000, $past(s_r.tx_snap[15:0])})
		else $error("mid word read returned wrong data");

	AST_HIGH_WORD: assert property (
		high_clear |=> axi_rsp.rvalid
			&& axi_rsp.rdata == {16'h0000, $past(s_r.tx_snap[31:16])})
		else $error("high word read returned wrong data");

	AST_CNT_READ_OKAY: assert property (
		(idle_clear || high_clear || mid_read || low_read)
			|=> axi_rsp.rresp == `RESP_OKAY)
		else $error("counter read answered with an error code");

	// bus answers, holds and refusals
	AST_RD_ANSWER: assert property (
		rd_take |=> axi_rsp.rvalid)
		else $error("read address taken but no read answer");

	AST_RVALID_HOLD: assert property (
		axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read answer dropped or changed before rready");

	AST_DECERR_READ: assert property (
		rd_take && (rd_idx < `IDX_IDLE_RX_ERR || rd_idx > `IDX_COUNT_CTRL)
			|=> axi_rsp.rresp == `RESP_DECERR && axi_rsp.rdata == 32'h0000_0000)
		else $error("unmapped read not refused");

	AST_WR_ANSWER: assert property (
		wr_do |=> axi_rsp.bvalid)
		else $error("write taken but no write response");

	AST_BVALID_HOLD: assert property (
		axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped or changed before bready");

	AST_WR_REFUSED: assert property (
		wr_do && s_r.aw_idx != `IDX_COUNT_CTRL |=> axi_rsp.bresp != `RESP_OKAY)
		else $error("write to a read-only counter was accepted");

	// control word changes only on a strobed control write
	AST_CTRL_WRITE: assert property (
		wr_do && s_r.aw_idx == `IDX_COUNT_CTRL && s_r.w_strb0
			|=> s_r.ctrl == $past(s_r.w_ctl))
		else $error("strobed control write did not land");

	AST_CTRL_KEEP: assert property (
		!(wr_do && s_r.aw_idx == `IDX_COUNT_CTRL && s_r.w_strb0) |=> $stable(s_r.ctrl))
		else $error("control word changed without a strobed write");

	COV_IDLE_ERR: cover property (idle_hit ##[1:20] idle_clear);
	COV_TX_SEQ: cover property (low_read ##[1:10] mid_read ##[1:10] high_clear);
	COV_CLEAR_RACE: cover property (high_clear && tx_hit);
	COV_CTRL_WRITE: cover property (wr_do && s_r.aw_idx == `IDX_COUNT_CTRL);
	COV_IDLE_RACE: cover property (idle_clear && idle_hit);

endmodule : phy_packet_error_counters

// ===== testbench/mac_model.sv
// Purpose: far-side stand-in driving the receive control line and tx packet pulses
// Assumes: levels change just after a rising clk_sys edge
// Notes:   rise level carries valid, fall level carries valid xor error
`timescale 1ns/1ps
module mac_model (
	// clock
	input  wire logic clk_sys,
	// pins toward the counters
	output logic      rx_control_rise,
	output logic      rx_control_fall,
	output logic      tx_packet_done
);
	// idle line at time zero
	initial begin
		rx_control_rise = 1'b0;
		rx_control_fall = 1'b0;
		tx_packet_done  = 1'b0;
	end

	// one burst of levels r and f; long holds so the two-flop sync sees every level
	task automatic rx_err(input logic r, input logic f);
		@(posedge clk_sys);
		rx_control_rise <= r;
		rx_control_fall <= f;
		repeat (4) @(posedge clk_sys);
		rx_control_rise <= 1'b0;
		rx_control_fall <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : rx_err

	// n packets, each a single-cycle pulse with a gap
	task automatic tx_pkts(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			tx_packet_done <= 1'b1;
			@(posedge clk_sys);
			tx_packet_done <= 1'b0;
		end
		repeat (2) @(posedge clk_sys);
	endtask : tx_pkts
endmodule : mac_model

// ===== testbench/test_phy_packet_error_counters.sv
// Purpose: self-checking bench of the packet and error counters
// Assumes: master holds each bus channel until the edge of its own ready
// Notes:   readies and answers are looked at on the falling edge, where settled
`timescale 1ns/1ps
`include "phy_cnt_params.svh"
module test_phy_packet_error_counters;
	import phy_cnt_pkg::*;
	localparam logic [7:0] A_IDLE = {`IDX_IDLE_RX_ERR, 2'b00};
	localparam logic [7:0] A_HIGH = {`IDX_TX_PKT_HIGH, 2'b00};
	localparam logic [7:0] A_MID  = {`IDX_TX_PKT_MID, 2'b00};
	localparam logic [7:0] A_LOW  = {`IDX_TX_PKT_LOW, 2'b00};
	localparam logic [7:0] A_CTRL = {`IDX_COUNT_CTRL, 2'b00};
	logic        clk_sys;
	logic        reset;
	logic        rx_control_rise;
	logic        rx_control_fall;
	logic        tx_packet_done;
	axi_req_type axi_req;
	axi_rsp_type axi_rsp;
	int          num_errors;
	int          n_compared;

	phy_packet_error_counters u_dut (.clk_sys(clk_sys), .reset(reset),
		.rx_control_rise(rx_control_rise), .rx_control_fall(rx_control_fall),
		.tx_packet_done(tx_packet_done), .axi_req(axi_req), .axi_rsp(axi_rsp));
	mac_model u_mac (.clk_sys(clk_sys), .rx_control_rise(rx_control_rise),
		.rx_control_fall(rx_control_fall), .tx_packet_done(tx_packet_done));

	// 40 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic stop_test;
		if (num_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// a wait that used its bound ends the run as failed
	task automatic bound(input int n);
		if (n >= 40) begin
			num_errors++;
			stop_test();
		end
	endtask : bound

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge clk_sys);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr  <= a;
		axi_req.rready  <= 1'b1;
		@(negedge clk_sys);
		for (n = 0; n < 40 && axi_rsp.arready !== 1'b1; n++) @(negedge clk_sys);
		bound(n);
		@(posedge clk_sys);
		axi_req.arvalid <= 1'b0;
		@(negedge clk_sys);
		for (n = 0; n < 40 && axi_rsp.rvalid !== 1'b1; n++) @(negedge clk_sys);
		bound(n);
		check(axi_rsp.rdata, ed);
		check({30'h0, axi_rsp.rresp}, {30'h0, er});
		@(posedge clk_sys);
		axi_req.rready <= 1'b0;
	endtask : rd

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int   n;
		logic aw;
		logic w;
		@(posedge clk_sys);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr  <= a;
		axi_req.wvalid  <= 1'b1;
		axi_req.wdata   <= d;
		axi_req.wstrb   <= s;
		axi_req.bready  <= 1'b1;
		aw = 1'b1;
		w  = 1'b1;
		for (n = 0; n < 40 && (aw || w); n++) begin
			@(negedge clk_sys);
			aw = aw && axi_rsp.awready !== 1'b1;
			w  = w && axi_rsp.wready !== 1'b1;
			@(posedge clk_sys);
			if (!aw) axi_req.awvalid <= 1'b0;
			if (!w) axi_req.wvalid <= 1'b0;
		end
		bound(n);
		@(negedge clk_sys);
		for (n = 0; n < 40 && axi_rsp.bvalid !== 1'b1; n++) @(negedge clk_sys);
		bound(n);
		check({30'h0, axi_rsp.bresp}, {30'h0, er});
		@(posedge clk_sys);
		axi_req.bready <= 1'b0;
	endtask : wr

	// reset values, unmapped read, write to a counter refused
	task automatic sc_reset;
		rd(A_IDLE, 32'h0, `RESP_OKAY);
		rd(A_LOW, 32'h0, `RESP_OKAY);
		rd(A_MID, 32'h0, `RESP_OKAY);
		rd(A_HIGH, 32'h0, `RESP_OKAY);
		rd(8'h00, 32'h0, `RESP_DECERR);
		rd(A_CTRL, 32'h3, `RESP_OKAY);
		wr(A_LOW, 32'h1234, 4'hF, `RESP_SLVERR);
	endtask : sc_reset

	// idle errors count, errors inside data and plain data do not, read clears
	task automatic sc_idle;
		repeat (3) u_mac.rx_err(1'b0, 1'b1);
		u_mac.rx_err(1'b1, 1'b0);
		u_mac.rx_err(1'b1, 1'b1);
		rd(A_IDLE, 32'h3, `RESP_OKAY);
		rd(A_IDLE, 32'h0, `RESP_OKAY);
	endtask : sc_idle

	// low, mid, high order; low reads keep the count, high clears it
	task automatic sc_tx;
		u_mac.tx_pkts(5);
		rd(A_LOW, 32'h5, `RESP_OKAY);
		rd(A_LOW, 32'h5, `RESP_OKAY);
		u_mac.tx_pkts(3);
		rd(A_LOW, 32'h8, `RESP_OKAY);
		u_mac.tx_pkts(1);
		rd(A_MID, 32'h0, `RESP_OKAY);
		rd(A_HIGH, 32'h0, `RESP_OKAY);
		rd(A_LOW, 32'h0, `RESP_OKAY);
	endtask : sc_tx

	// each counter switched off in turn, unstrobed write ignored, readback
	task automatic sc_ctrl;
		wr(A_CTRL, 32'h1, 4'hF, `RESP_OKAY);
		u_mac.tx_pkts(2);
		rd(A_LOW, 32'h0, `RESP_OKAY);
		wr(A_CTRL, 32'h3, 4'h0, `RESP_OKAY);
		rd(A_CTRL, 32'h1, `RESP_OKAY);
		wr(A_CTRL, 32'h2, 4'hF, `RESP_OKAY);
		u_mac.rx_err(1'b0, 1'b1);
		rd(A_IDLE, 32'h0, `RESP_OKAY);
		u_mac.tx_pkts(2);
		rd(A_LOW, 32'h2, `RESP_OKAY);
		wr(A_CTRL, 32'h3, 4'hF, `RESP_OKAY);
	endtask : sc_ctrl

	// reset in mid-run brings counters and control word back
	task automatic sc_rst;
		u_mac.rx_err(1'b0, 1'b1);
		u_mac.tx_pkts(1);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rd(A_IDLE, 32'h0, `RESP_OKAY);
		rd(A_LOW, 32'h0, `RESP_OKAY);
		rd(A_CTRL, 32'h3, `RESP_OKAY);
	endtask : sc_rst

	// main sequence
	initial begin
		reset      = 1'b1;
		axi_req    = '0;
		num_errors = 0;
		n_compared = 0;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		sc_reset();
		sc_idle();
		sc_tx();
		sc_ctrl();
		sc_rst();
		stop_test();
	end
endmodule : test_phy_packet_error_counters
